// file: core/jgbu_pkg.sv
// Constants, types and decode helpers for the jump group branch unit.
// Assumes one machine T state per clock edge.
package jgbu_pkg;

  // Opcodes
  localparam logic [7:0] OP_JUMP_ABSOLUTE = 8'hc3;
  localparam logic [7:0] OP_BRANCH_ALWAYS = 8'h18;
  localparam logic [7:0] OP_BRANCH_CARRY = 8'h38;
  localparam logic [7:0] OP_BRANCH_NOCARRY = 8'h30;
  localparam logic [7:0] OP_BRANCH_ZERO = 8'h28;
  localparam logic [7:0] OP_BRANCH_NONZERO = 8'h20;
  localparam logic [7:0] OP_JUMP_INDIRECT = 8'he9;
  localparam logic [7:0] OP_INDEX_PREFIX = 8'hdd;
  localparam logic [1:0] COND_ABS_TOP = 2'h3;
  localparam logic [2:0] COND_ABS_LOW = 3'h2;

  // Flag bit positions
  localparam int FLAG_SIGN = 7;
  localparam int FLAG_ZERO = 6;
  localparam int FLAG_PARITY = 2;
  localparam int FLAG_CARRY = 0;

  // Last T state index of each machine cycle kind
  localparam logic [2:0] T_FETCH_LAST = 3'h3;
  localparam logic [2:0] T_OPERAND_LAST = 3'h2;
  localparam logic [2:0] T_REL_ADD_LAST = 3'h4;

  // Clocks from one done pulse to the next
  localparam logic [3:0] LEN_ABSOLUTE = 4'ha;
  localparam logic [3:0] LEN_REL_TAKEN = 4'hc;
  localparam logic [3:0] LEN_REL_SKIP = 4'h7;
  localparam logic [3:0] LEN_INDIRECT = 4'h4;
  localparam logic [3:0] LEN_INDEXED = 4'h8;

  localparam logic [15:0] RESET_PC = 16'h0000;

  typedef enum logic [1:0] {
    S_FETCH = 2'b00,
    S_OPER1 = 2'b01,
    S_OPER2 = 2'b11,
    S_RELX = 2'b10
  } jgbu_state_e;

  typedef enum logic [2:0] {
    CL_ABS, CL_ABS_COND, CL_REL, CL_REL_COND, CL_IND, CL_PREFIX, CL_OTHER
  } jgbu_class_e;

  typedef struct packed {
    jgbu_state_e st;
    logic [2:0] tcnt;
    logic [15:0] pc;
    logic [15:0] start_pc;
    logic [7:0] opcode;
    logic [7:0] lo;
    logic [7:0] hi;
    logic prefix;
    logic take;
    logic mem_rd;
    logic m1;
    logic done;
    logic unsup;
  } jgbu_state_s;

  function automatic jgbu_class_e jgbu_classify(input logic [7:0] op);
    jgbu_class_e c;
    c = CL_OTHER;
    if (op == OP_JUMP_ABSOLUTE) c = CL_ABS;
    else if (op[7:6] == COND_ABS_TOP && op[2:0] == COND_ABS_LOW) c = CL_ABS_COND;
    else if (op == OP_BRANCH_ALWAYS) c = CL_REL;
    else if (op == OP_BRANCH_CARRY || op == OP_BRANCH_NOCARRY ||
             op == OP_BRANCH_ZERO || op == OP_BRANCH_NONZERO) c = CL_REL_COND;
    else if (op == OP_JUMP_INDIRECT) c = CL_IND;
    else if (op == OP_INDEX_PREFIX) c = CL_PREFIX;
    return c;
  endfunction : jgbu_classify

  function automatic logic jgbu_cond_met(input logic [2:0] condition_field,
                                         input logic [7:0] flags);
    logic r;
    case (condition_field)
      3'h0: r = !flags[FLAG_ZERO];
      3'h1: r = flags[FLAG_ZERO];
      3'h2: r = !flags[FLAG_CARRY];
      3'h3: r = flags[FLAG_CARRY];
      3'h4: r = !flags[FLAG_PARITY];
      3'h5: r = flags[FLAG_PARITY];
      3'h6: r = !flags[FLAG_SIGN];
      default: r = flags[FLAG_SIGN];
    endcase
    return r;
  endfunction : jgbu_cond_met

endpackage : jgbu_pkg

// file: core/jgbu_core.sv
// Jump group fetch, decode and program counter update.
// Assumes program memory answers within one machine cycle and flags and
// register pairs are held stable by the rest of the processor.
`timescale 1ns/100ps
`default_nettype none

// Behaviour
// RULE1: Opcode c3 loads two operand bytes into counter, 10 T states 4,3,3.
// RULE2: First operand byte is low address byte, second is high.
// RULE3: Conditional absolute jump loads target if condition holds, else continues.
// RULE4: Condition field selects nonzero, zero, no carry, carry, parity odd/even, sign.
// RULE5: Condition taken from flags; conditional absolute always 10 T states.
// RULE6: Opcode 18 adds signed displacement, 12 T states 4,3,5.
// RULE7: Displacement added after counter passes both bytes.
// RULE8: Opcode 38 branches when carry set, else continues.
// RULE9: Opcode 30 branches when carry clear, else continues.
// RULE10: Opcode 28 branches when zero set, else continues.
// RULE11: Opcode 20 branches when zero clear, else continues.
// RULE12: Failed relative branch 7 T states; taken one 12 T states.
// RULE13: Opcode e9 copies main pointer pair into counter, 4 T states.
// RULE14: Prefix dd then e9 copies first index pair, 8 T states 4,4.
// RULE15: No jump instruction changes any flag.
// RULE16: Conditional absolute opcode is 11, condition field, 010; two operands follow.
// RULE17: Untaken conditional jumps still consume all operand bytes.
module jgbu_core (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Program memory
  output logic [15:0] mem_addr,
  output logic mem_rd,
  output logic opcode_fetch,
  input wire logic [7:0] mem_rdata,
  // Processor state read by the block
  input wire logic [7:0] flags,
  input wire logic [15:0] main_pointer_pair,
  input wire logic [15:0] first_index_pair,
  // Status
  output logic [15:0] pc,
  output logic instr_done,
  output logic instr_unsupported
);

  jgbu_pkg::jgbu_state_s q, d;
  jgbu_pkg::jgbu_class_e cls_fetch, cls_held;
  logic take_fetch;

  // Flags are only read here, never written
  always_comb begin
    cls_fetch = jgbu_pkg::jgbu_classify(mem_rdata); // RULE16
    cls_held = jgbu_pkg::jgbu_classify(q.opcode);
    case (cls_fetch)
      jgbu_pkg::CL_ABS_COND: take_fetch = jgbu_pkg::jgbu_cond_met(mem_rdata[5:3], flags); // RULE4 RULE5 RULE15
      // Relative conditions reuse the low half of the condition table
      jgbu_pkg::CL_REL_COND: take_fetch = jgbu_pkg::jgbu_cond_met({1'b0, mem_rdata[4:3]}, flags); // RULE8 RULE9 RULE10 RULE11
      default: take_fetch = 1'b1;
    endcase
  end

  always_comb begin
    d = q;
    d.done = 1'b0;
    d.unsup = 1'b0;
    d.tcnt = q.tcnt + 3'h1;
    case (q.st)
      jgbu_pkg::S_FETCH: begin
        if (q.tcnt == '0 && !q.prefix) begin
          d.start_pc = q.pc;
        end
        if (q.tcnt == jgbu_pkg::T_FETCH_LAST) begin
          d.tcnt = '0;
          d.opcode = mem_rdata;
          d.pc = q.pc + 16'h0001;
          if (q.prefix) begin
            d.prefix = 1'b0;
            d.done = 1'b1;
            if (mem_rdata == jgbu_pkg::OP_JUMP_INDIRECT) begin
              d.pc = first_index_pair; // RULE14
            end else begin
              d.unsup = 1'b1;
            end
          end else begin
            case (cls_fetch)
              jgbu_pkg::CL_ABS, jgbu_pkg::CL_ABS_COND,
              jgbu_pkg::CL_REL, jgbu_pkg::CL_REL_COND: begin
                d.st = jgbu_pkg::S_OPER1;
                d.take = take_fetch;
              end
              jgbu_pkg::CL_IND: begin
                d.pc = main_pointer_pair; // RULE13
                d.done = 1'b1;
              end
              jgbu_pkg::CL_PREFIX: begin
                d.prefix = 1'b1;
              end
              default: begin
                // Foreign opcodes retire as one 4-state cycle so the stream moves on
                d.done = 1'b1;
                d.unsup = 1'b1;
              end
            endcase
          end
        end
      end
      jgbu_pkg::S_OPER1: begin
        if (q.tcnt == jgbu_pkg::T_OPERAND_LAST) begin
          d.tcnt = '0;
          d.lo = mem_rdata; // RULE2
          d.pc = q.pc + 16'h0001; // RULE7 RULE17
          if (cls_held == jgbu_pkg::CL_ABS || cls_held == jgbu_pkg::CL_ABS_COND) begin
            d.st = jgbu_pkg::S_OPER2; // RULE1 RULE5
          end else if (q.take) begin
            d.st = jgbu_pkg::S_RELX; // RULE6 RULE12
          end else begin
            d.st = jgbu_pkg::S_FETCH; // RULE12
            d.done = 1'b1;
          end
        end
      end
      jgbu_pkg::S_OPER2: begin
        if (q.tcnt == jgbu_pkg::T_OPERAND_LAST) begin
          d.tcnt = '0;
          d.hi = mem_rdata;
          d.st = jgbu_pkg::S_FETCH;
          d.done = 1'b1;
          // Untaken still read both bytes
          d.pc = q.take ? {mem_rdata, q.lo} : q.pc + 16'h0001; // RULE1 RULE2 RULE3 RULE17
        end
      end
      jgbu_pkg::S_RELX: begin
        if (q.tcnt == jgbu_pkg::T_REL_ADD_LAST) begin
          d.tcnt = '0;
          d.st = jgbu_pkg::S_FETCH;
          d.done = 1'b1;
          d.pc = q.pc + {{8{q.lo[7]}}, q.lo}; // RULE7
        end
      end
      default: begin
        d.st = jgbu_pkg::S_FETCH;
        d.tcnt = '0;
      end
    endcase
    // Adder cycle is internal; memory idles then
    d.mem_rd = (d.st != jgbu_pkg::S_RELX);
    d.m1 = (d.st == jgbu_pkg::S_FETCH);
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      q <= '{st: jgbu_pkg::S_FETCH, tcnt: '0, pc: jgbu_pkg::RESET_PC,
             start_pc: jgbu_pkg::RESET_PC, opcode: '0, lo: '0, hi: '0,
             prefix: 1'b0, take: 1'b0, mem_rd: 1'b1, m1: 1'b1, done: 1'b0,
             unsup: 1'b0};
    end else begin
      q <= d;
    end
  end

  assign mem_addr = q.pc;
  assign mem_rd = q.mem_rd;
  assign opcode_fetch = q.m1;
  assign pc = q.pc;
  assign instr_done = q.done;
  assign instr_unsupported = q.unsup;

  // Checking helpers: clocks between done pulses
  logic [3:0] since_done_q;
  logic seen_done_q;
  logic was_prefixed_q;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      since_done_q <= 4'h0;
      seen_done_q <= 1'b0;
      was_prefixed_q <= 1'b0;
    end else begin
      since_done_q <= q.done ? 4'h1 : since_done_q + 4'h1;
      seen_done_q <= seen_done_q | q.done;
      if (q.prefix) was_prefixed_q <= 1'b1;
      else if (q.done) was_prefixed_q <= 1'b0;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  logic chk;
  logic is_rel;
  assign chk = q.done && seen_done_q && !q.unsup;
  assign is_rel = (cls_held == jgbu_pkg::CL_REL || cls_held == jgbu_pkg::CL_REL_COND);

  a_absolute_len: assert property (chk && q.opcode == jgbu_pkg::OP_JUMP_ABSOLUTE |-> // RULE1
    since_done_q == jgbu_pkg::LEN_ABSOLUTE) else $error("absolute jump length wrong");
  // A prefix followed by a jump opcode other than e9 retires as unsupported with stale operands
  a_absolute_target: assert property (q.done && !q.unsup && cls_held == jgbu_pkg::CL_ABS |-> // RULE2
    pc == {q.hi, q.lo}) else $error("absolute target byte order wrong");
  a_cond_abs_len: assert property (chk && cls_held == jgbu_pkg::CL_ABS_COND |-> // RULE5
    since_done_q == jgbu_pkg::LEN_ABSOLUTE) else $error("conditional absolute length wrong");
  a_cond_abs_skip: assert property (q.done && !q.unsup && cls_held == jgbu_pkg::CL_ABS_COND && !q.take |-> // RULE3
    pc == q.start_pc + 16'h0003) else $error("untaken jump not past operands");
  a_cond_eval: assert property (q.st == jgbu_pkg::S_FETCH && q.tcnt == jgbu_pkg::T_FETCH_LAST // RULE4
    && !q.prefix && cls_fetch == jgbu_pkg::CL_ABS_COND |=> q.take ==
    jgbu_pkg::jgbu_cond_met($past(mem_rdata[5:3]), $past(flags)))
    else $error("condition decode wrong");
  a_rel_taken_len: assert property (chk && is_rel && q.take && !was_prefixed_q |-> // RULE6
    since_done_q == jgbu_pkg::LEN_REL_TAKEN) else $error("taken branch length wrong");
  a_rel_skip_len: assert property (chk && is_rel && !q.take && !was_prefixed_q |-> // RULE12
    since_done_q == jgbu_pkg::LEN_REL_SKIP) else $error("untaken branch length wrong");
  a_rel_target: assert property (q.done && is_rel && !was_prefixed_q |-> // RULE7
    pc == (q.take ? q.start_pc + 16'h0002 + {{8{q.lo[7]}}, q.lo} : q.start_pc + 16'h0002))
    else $error("branch target wrong");
  a_indirect_main: assert property (chk && q.opcode == jgbu_pkg::OP_JUMP_INDIRECT // RULE13
    && !was_prefixed_q |-> since_done_q == jgbu_pkg::LEN_INDIRECT && pc == $past(main_pointer_pair))
    else $error("main pointer jump wrong");
  a_indirect_index: assert property (chk && q.opcode == jgbu_pkg::OP_JUMP_INDIRECT // RULE14
    && was_prefixed_q |-> since_done_q == jgbu_pkg::LEN_INDEXED && pc == $past(first_index_pair))
    else $error("index jump wrong");
  a_relx_no_read: assert property (q.st == jgbu_pkg::S_RELX |-> !mem_rd && !opcode_fetch) // RULE6
    else $error("memory read during adder cycle");

  c_abs_taken: cover property (q.done && cls_held == jgbu_pkg::CL_ABS_COND && q.take);
  c_rel_taken: cover property (q.done && cls_held == jgbu_pkg::CL_REL_COND && q.take);
  c_rel_skip: cover property (q.done && cls_held == jgbu_pkg::CL_REL_COND && !q.take);
  c_index_jump: cover property (q.done && was_prefixed_q && !q.unsup);

endmodule : jgbu_core

`default_nettype wire

// file: bench/jgbu_mem_model.sv
// Program memory model holding opcode and operand bytes.
// Assumes the bench fills mem before each instruction is fetched.
`timescale 1ns/100ps
`default_nettype none
module jgbu_mem_model (
  // Clock
  input wire logic clk,
  // Read port
  input wire logic [15:0] mem_addr,
  input wire logic mem_rd,
  output logic [7:0] mem_rdata
);
  logic [7:0] mem [0:65535];
  logic [7:0] last_q;
  always_ff @(posedge clk) begin
    if (mem_rd) last_q <= mem[mem_addr];
  end
  // Released bus shows the inverse, so a stale byte never passes
  assign mem_rdata = mem_rd ? mem[mem_addr] : ~last_q;
endmodule : jgbu_mem_model
`default_nettype wire

// file: bench/jgbu_tb_top.sv
// Self-checking bench for the jump group core.
// Assumes the memory model answers combinationally at mem_addr.
`timescale 1ns/100ps
`default_nettype none
module jump_group_branch_unit_tb_top;
  localparam int MAX_CYCLES = 8000;
  logic clk, reset_n, mem_rd, opcode_fetch, instr_done, instr_unsupported;
  logic [15:0] mem_addr, pc, main_pointer_pair, first_index_pair, cur, seed;
  logic [7:0] mem_rdata, flags, op, b1;
  logic [7:0] ops [10] = '{8'hc3, 8'h18, 8'h20, 8'h28, 8'h30, 8'h38, 8'he9, 8'hdd, 8'h00, 8'hc2};
  int n_mismatch, samples_checked, cycles, k;

  jgbu_core dut (.clk(clk), .reset_n(reset_n), .mem_addr(mem_addr), .mem_rd(mem_rd),
    .opcode_fetch(opcode_fetch), .mem_rdata(mem_rdata), .flags(flags),
    .main_pointer_pair(main_pointer_pair), .first_index_pair(first_index_pair),
    .pc(pc), .instr_done(instr_done), .instr_unsupported(instr_unsupported));
  jgbu_mem_model mem_i (.clk(clk), .mem_addr(mem_addr), .mem_rd(mem_rd),
    .mem_rdata(mem_rdata));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr

  function automatic logic cond_ok(input logic [2:0] c, input logic [7:0] f);
    logic b;
    case (c[2:1])
      2'h0: b = f[jgbu_pkg::FLAG_ZERO];
      2'h1: b = f[jgbu_pkg::FLAG_CARRY];
      2'h2: b = f[jgbu_pkg::FLAG_PARITY];
      default: b = f[jgbu_pkg::FLAG_SIGN];
    endcase
    return b == c[0];
  endfunction : cond_ok

  // Next counter, length, adder cycles, fetch cycles, unsupported flag
  function automatic int exp_len(input logic [7:0] o, x, y, input logic [15:0] a,
      output logic [15:0] np, output int rd0, output int ofc, output logic us);
    logic rel;
    rel = o[7:5] == 3'h1 && o[2:0] == 3'h0;
    rd0 = 0;
    ofc = 4;
    us = 1'b0;
    if (o == 8'hc3) begin
      np = {y, x};
      return 10;
    end
    if (o[7:6] == 2'h3 && o[2:0] == 3'h2) begin
      np = cond_ok(o[5:3], flags) ? {y, x} : a + 16'h3;
      return 10;
    end
    if (o == 8'h18 || (rel && cond_ok({1'b0, o[4:3]}, flags))) begin
      np = a + 16'h2 + {{8{x[7]}}, x};
      rd0 = 5;
      return 12;
    end
    np = a + 16'h2;
    if (rel) return 7;
    if (o == 8'he9) begin
      np = main_pointer_pair;
      return 4;
    end
    if (o == 8'hdd) begin
      ofc = 8;
      us = x != 8'he9;
      if (!us) np = first_index_pair;
      return 8;
    end
    np = a + 16'h1;
    us = 1'b1;
    return 4;
  endfunction : exp_len

  task automatic report_and_stop();
    if (n_mismatch == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop

  task automatic chk_v(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_v

  task automatic chk_n(input int got, input int exp);
    chk_v(16'(got), 16'(exp));
  endtask : chk_n

  task automatic rnd();
    seed = lfsr(seed);
    flags = seed[7:0];
    seed = lfsr(seed);
    main_pointer_pair = seed;
    seed = lfsr(seed);
    first_index_pair = seed;
    seed = lfsr(seed);
  endtask : rnd

  task automatic step(input logic [7:0] o, x, y, input bit first);
    logic [15:0] np;
    logic us;
    int n, rd0, ofc, len, nrd0, nof;
    mem_i.mem[cur] = o;
    mem_i.mem[cur + 16'h1] = x;
    mem_i.mem[cur + 16'h2] = y;
    len = exp_len(o, x, y, cur, np, rd0, ofc, us);
    n = 0;
    nrd0 = 0;
    nof = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
      nrd0 += int'(mem_rd === 1'b0);
      nof += int'(opcode_fetch === 1'b1);
    end while (instr_done !== 1'b1 && n < 20);
    chk_v(pc, np);
    chk_v(mem_addr, np);
    chk_v(16'(instr_unsupported), 16'(us));
    if (!first) begin
      chk_n(n, len);
      chk_n(nrd0, rd0);
      chk_n(nof, ofc);
    end
    cur = np;
  endtask : step

  always @(posedge clk) begin
    cycles++;
    if (cycles == MAX_CYCLES) begin
      n_mismatch++;
      report_and_stop();
    end
  end

  initial begin
    reset_n = 1'b0;
    flags = 8'h00;
    main_pointer_pair = 16'h0000;
    first_index_pair = 16'h0000;
    seed = 16'h0022;
    cur = 16'h0000;
    repeat (2) @(posedge clk);
    #1;
    reset_n = 1'b1;
    step(8'hc3, 8'h34, 8'h12, 1'b1);
    for (int i = 0; i < 16; i++) begin
      flags = i[3] ? 8'hff : 8'h00;
      step({2'h3, i[2:0], 3'h2}, 8'h00, {4'h4, i[3:0]}, 1'b0);
      step({3'h1, i[1:0], 3'h0}, i[2] ? 8'h80 : 8'h7f, 8'h00, 1'b0);
    end
    step(8'h18, 8'hfe, 8'h00, 1'b0);
    step(8'hdd, 8'h00, 8'h00, 1'b0);
    for (int i = 0; i < 200; i++) begin
      rnd();
      k = int'(seed[3:0]) % 10;
      op = ops[k];
      if (k == 9) op[5:3] = seed[6:4];
      b1 = (k == 7 && !seed[12]) ? 8'he9 : seed[15:8];
      seed = lfsr(seed);
      step(op, b1, seed[7:0], 1'b0);
    end
    report_and_stop();
  end
endmodule : jump_group_branch_unit_tb_top
`default_nettype wire
